// >>> rtl/fsf_fault_status_bank.sv
// fault status register bank: crc, otp bank, overcurrent flags, pin readback
`timescale 1ns/1ps
// Function
// R1: section one crc fault clears bit 15
// R2: section two crc fault clears bit 14
// R3: section three crc fault clears bit 13
// R4: flags read 0 on fault, write 1 restores
// R5: internal memory crc fault clears bit 11
// R6: host resets device on repeating memory fault; host model asks on the first one read
// R7: bit 10 reports selected otp bank
// R8: bank bit excluded from summary digital fault
// R9: host resets device when backup bank used
// R10: digital status at 05h, reset ec00h, zeros
// R11: channel a high persistence clears bit 3
// R12: channel a low persistence clears bit 2
// R13: channel b high persistence clears bit 1
// R14: channel b low persistence clears bit 0
// R15: overcurrent status at 06h, reset 000fh
// R16: pin readback at 07h, resets to 0000h
// R17: flags stay low until host restores
// R18: zero writes and read-only writes change nothing
module fsf_fault_status_bank #(
	parameter int PERSIST_W = fsf_pkg::PERSIST_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire fsf_pkg::fsf_reg_req_s reg_req,
	output logic [15:0] reg_rdata_ff,
	output logic reg_rd_valid_ff,
	output logic reg_addr_err_ff,
	input wire fsf_pkg::fsf_crc_evt_s crc_evt,
	input wire logic otp_backup_sel,
	input wire fsf_pkg::fsf_occ_cmp_s occ_cmp,
	input wire logic [PERSIST_W-1:0] occ_persist_limit,
	input wire logic [fsf_pkg::PIN_RB_W-1:0] pin_readback_in,
	output logic summary_digital_fault_n_ff,
	output logic summary_occ_fault_n_ff,
	output logic boot_done_ff
);

	// true when a request addresses the given register
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		addr_hit = (addr == target);
	endfunction

	// restore vector: ones written to writable bits of the addressed register
	function automatic logic [15:0] w1_restore(
		input fsf_pkg::fsf_reg_req_s req,
		input logic [7:0] target,
		input logic [15:0] mask
	);
		w1_restore = (req.wr && addr_hit(req.addr, target)) ? (req.wdata & mask) : 16'h0000;
	endfunction

	// picks four flag bits out of a register-wide vector, highest first
	function automatic logic [3:0] gather4(
		input logic [15:0] v,
		input int p3,
		input int p2,
		input int p1,
		input int p0
	);
		gather4 = {v[p3], v[p2], v[p1], v[p0]};
	endfunction

	logic [15:0] dig_restore;
	logic [15:0] occ_restore;
	logic [fsf_pkg::NUM_DIG_FLAGS-1:0] dig_evt_vec;
	logic [fsf_pkg::NUM_DIG_FLAGS-1:0] dig_restore_vec;
	logic [fsf_pkg::NUM_DIG_FLAGS-1:0] dig_flags_n;
	logic [fsf_pkg::NUM_OCC_FLAGS-1:0] occ_evt_vec;
	logic [fsf_pkg::NUM_OCC_FLAGS-1:0] occ_restore_vec;
	logic [fsf_pkg::NUM_OCC_FLAGS-1:0] occ_flags_n;
	logic a_high_trip;
	logic a_low_trip;
	logic b_high_trip;
	logic b_low_trip;
	logic otp_bank_ff;
	logic [fsf_pkg::PIN_RB_W-1:0] pin_rb_ff;
	fsf_pkg::fsf_boot_e boot_state_ff;
	fsf_pkg::fsf_boot_e nxt_boot_state;
	logic [15:0] dig_status;
	logic [15:0] overcurrent_trip_status;
	logic [15:0] pin_status;
	logic [15:0] nxt_rdata;
	logic nxt_addr_err;

	// write decode; read-only and reserved bits are masked out
	assign dig_restore = w1_restore(reg_req, fsf_pkg::ADDR_DIG_STATUS,
		fsf_pkg::MASK_DIG_W1R); // [R18]
	assign occ_restore = w1_restore(reg_req, fsf_pkg::ADDR_OVERCURRENT_TRIP_STATUS,
		fsf_pkg::MASK_OCC_W1R); // [R18]

	// digital flags, index 3..0 = section one, two, three, memory
	assign dig_evt_vec = {crc_evt.cfg_one, crc_evt.cfg_two, crc_evt.cfg_three,
		crc_evt.mem}; // [R1] [R2] [R3] [R5]
	assign dig_restore_vec = gather4(dig_restore, fsf_pkg::BIT_CFG_ONE_CRC,
		fsf_pkg::BIT_CFG_TWO_CRC, fsf_pkg::BIT_CFG_THREE_CRC, fsf_pkg::BIT_MEM_CRC);

	// sticky flags; an event beats a same-cycle restore [R4] [R17]
	fsf_flag_cell #(
		.N(fsf_pkg::NUM_DIG_FLAGS)
	) u_dig_flags (
		.clk(clk),
		.reset_n(reset_n),
		.fault_evt(dig_evt_vec),
		.restore(dig_restore_vec),
		.flags_n_ff(dig_flags_n)
	);

	// overcurrent persistence per channel and direction
	fsf_trip_persist #(
		.CW(PERSIST_W)
	) u_a_high (
		.clk(clk),
		.reset_n(reset_n),
		.conv_strobe(occ_cmp.conv_a),
		.past_threshold(occ_cmp.a_above_high),
		.limit(occ_persist_limit),
		.trip_ff(a_high_trip)
	); // [R11]

	fsf_trip_persist #(
		.CW(PERSIST_W)
	) u_a_low (
		.clk(clk),
		.reset_n(reset_n),
		.conv_strobe(occ_cmp.conv_a),
		.past_threshold(occ_cmp.a_below_low),
		.limit(occ_persist_limit),
		.trip_ff(a_low_trip)
	); // [R12]

	fsf_trip_persist #(
		.CW(PERSIST_W)
	) u_b_high (
		.clk(clk),
		.reset_n(reset_n),
		.conv_strobe(occ_cmp.conv_b),
		.past_threshold(occ_cmp.b_above_high),
		.limit(occ_persist_limit),
		.trip_ff(b_high_trip)
	); // [R13]

	fsf_trip_persist #(
		.CW(PERSIST_W)
	) u_b_low (
		.clk(clk),
		.reset_n(reset_n),
		.conv_strobe(occ_cmp.conv_b),
		.past_threshold(occ_cmp.b_below_low),
		.limit(occ_persist_limit),
		.trip_ff(b_low_trip)
	); // [R14]

	// overcurrent flags, index 3..0 = a high, a low, b high, b low
	assign occ_evt_vec = {a_high_trip, a_low_trip, b_high_trip, b_low_trip};
	assign occ_restore_vec = gather4(occ_restore, fsf_pkg::BIT_A_HIGH,
		fsf_pkg::BIT_A_LOW, fsf_pkg::BIT_B_HIGH, fsf_pkg::BIT_B_LOW);

	// sticky trip flags; a trip beats a same-cycle restore [R4] [R17]
	fsf_flag_cell #(
		.N(fsf_pkg::NUM_OCC_FLAGS)
	) u_occ_flags (
		.clk(clk),
		.reset_n(reset_n),
		.fault_evt(occ_evt_vec),
		.restore(occ_restore_vec),
		.flags_n_ff(occ_flags_n)
	);

	// boot sequencer: the bank strap is caught on the second clock edge after reset release
	always_comb begin
		nxt_boot_state = boot_state_ff;
		unique case (boot_state_ff)
			fsf_pkg::BOOT_WAIT: begin
				nxt_boot_state = fsf_pkg::BOOT_CAPT;
			end
			fsf_pkg::BOOT_CAPT: begin
				nxt_boot_state = fsf_pkg::BOOT_RUN;
			end
			fsf_pkg::BOOT_RUN: begin
				nxt_boot_state = fsf_pkg::BOOT_RUN;
			end
			default: begin
				nxt_boot_state = fsf_pkg::BOOT_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_state_ff <= fsf_pkg::BOOT_WAIT;
		end else begin
			boot_state_ff <= nxt_boot_state;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_done_ff <= 1'b0;
		end else begin
			boot_done_ff <= (nxt_boot_state == fsf_pkg::BOOT_RUN);
		end
	end

	// bank bit: primary until the strap is caught, read-only afterwards
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			otp_bank_ff <= fsf_pkg::RST_DIG_STATUS[fsf_pkg::BIT_OTP_BANK];
		end else if (boot_state_ff == fsf_pkg::BOOT_CAPT) begin
			otp_bank_ff <= otp_backup_sel ? fsf_pkg::OTP_BACKUP : fsf_pkg::OTP_PRIMARY; // [R7]
		end
	end

	// pin readback sampled every cycle, cleared by reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_rb_ff <= fsf_pkg::RST_PIN_READBACK[fsf_pkg::PIN_RB_W-1:0]; // [R16]
		end else begin
			pin_rb_ff <= pin_readback_in;
		end
	end

	// register images; reserved bits forced to zero
	always_comb begin
		dig_status = 16'h0000; // [R10]
		dig_status[fsf_pkg::BIT_CFG_ONE_CRC] = dig_flags_n[3]; // [R1]
		dig_status[fsf_pkg::BIT_CFG_TWO_CRC] = dig_flags_n[2]; // [R2]
		dig_status[fsf_pkg::BIT_CFG_THREE_CRC] = dig_flags_n[1]; // [R3]
		dig_status[fsf_pkg::BIT_MEM_CRC] = dig_flags_n[0]; // [R5]
		dig_status[fsf_pkg::BIT_OTP_BANK] = otp_bank_ff; // [R7]
	end

	always_comb begin
		overcurrent_trip_status = 16'h0000; // [R15]
		overcurrent_trip_status[fsf_pkg::BIT_A_HIGH] = occ_flags_n[3]; // [R11]
		overcurrent_trip_status[fsf_pkg::BIT_A_LOW] = occ_flags_n[2]; // [R12]
		overcurrent_trip_status[fsf_pkg::BIT_B_HIGH] = occ_flags_n[1]; // [R13]
		overcurrent_trip_status[fsf_pkg::BIT_B_LOW] = occ_flags_n[0]; // [R14]
	end

	always_comb begin
		pin_status = 16'h0000; // [R16]
		pin_status[fsf_pkg::PIN_RB_W-1:0] = pin_rb_ff;
	end

	// read mux; unmapped addresses return zero and raise the error flag
	always_comb begin
		nxt_rdata = 16'h0000;
		nxt_addr_err = 1'b0;
		if (addr_hit(reg_req.addr, fsf_pkg::ADDR_DIG_STATUS)) begin
			nxt_rdata = dig_status; // [R10]
		end else if (addr_hit(reg_req.addr, fsf_pkg::ADDR_OVERCURRENT_TRIP_STATUS)) begin
			nxt_rdata = overcurrent_trip_status; // [R15]
		end else if (addr_hit(reg_req.addr, fsf_pkg::ADDR_PIN_READBACK)) begin
			nxt_rdata = pin_status; // [R16]
		end else begin
			nxt_addr_err = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd_valid_ff <= 1'b0;
		end else begin
			reg_rd_valid_ff <= reg_req.rd;
		end
	end

	// read data holds until the next read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_ff <= 16'h0000;
		end else if (reg_req.rd) begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_addr_err_ff <= 1'b0;
		end else begin
			reg_addr_err_ff <= (reg_req.rd || reg_req.wr) && nxt_addr_err;
		end
	end

	// summaries follow the flags one cycle later; bank bit left out
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			summary_digital_fault_n_ff <= 1'b1;
		end else begin
			summary_digital_fault_n_ff <= &dig_flags_n; // [R8]
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			summary_occ_fault_n_ff <= 1'b1;
		end else begin
			summary_occ_fault_n_ff <= &occ_flags_n;
		end
	end

endmodule

// >>> rtl/fsf_pkg.sv
// fault status flag bank: shared constants, carriers and state codes
package fsf_pkg;

	localparam int REG_AW = 8;
	localparam int REG_DW = 16;

	// register addresses
	localparam logic [7:0] ADDR_DIG_STATUS = 8'h05;
	localparam logic [7:0] ADDR_OVERCURRENT_TRIP_STATUS = 8'h06;
	localparam logic [7:0] ADDR_PIN_READBACK = 8'h07;

	// reset values
	localparam logic [15:0] RST_DIG_STATUS = 16'hec00;
	localparam logic [15:0] RST_OVERCURRENT_TRIP_STATUS = 16'h000f;
	localparam logic [15:0] RST_PIN_READBACK = 16'h0000;

	// digital status field positions
	localparam int BIT_CFG_ONE_CRC = 15;
	localparam int BIT_CFG_TWO_CRC = 14;
	localparam int BIT_CFG_THREE_CRC = 13;
	localparam int BIT_MEM_CRC = 11;
	localparam int BIT_OTP_BANK = 10;

	// overcurrent status field positions
	localparam int BIT_A_HIGH = 3;
	localparam int BIT_A_LOW = 2;
	localparam int BIT_B_HIGH = 1;
	localparam int BIT_B_LOW = 0;

	// writable (write-one-to-restore) bits of each register
	localparam logic [15:0] MASK_DIG_W1R = 16'he800;
	localparam logic [15:0] MASK_OCC_W1R = 16'h000f;
	// readback register: bits 9:0 carry data, the rest read zero
	localparam int PIN_RB_W = 10;

	// number of digital flags and overcurrent flags
	localparam int NUM_DIG_FLAGS = 4;
	localparam int NUM_OCC_FLAGS = 4;

	// persistence counter width and default count of conversions
	localparam int PERSIST_W = 8;
	localparam logic [7:0] PERSIST_DEF = 8'h01;

	// otp bank codes as seen in the status bit
	localparam logic OTP_PRIMARY = 1'b1;
	localparam logic OTP_BACKUP = 1'b0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} fsf_reg_req_s;

	typedef struct packed {
		logic cfg_one;
		logic cfg_two;
		logic cfg_three;
		logic mem;
	} fsf_crc_evt_s;

	typedef struct packed {
		logic conv_a;
		logic a_above_high;
		logic a_below_low;
		logic conv_b;
		logic b_above_high;
		logic b_below_low;
	} fsf_occ_cmp_s;

	// boot sequencer, gray along wait -> capture -> run
	typedef enum logic [1:0] {
		BOOT_WAIT = 2'b00,
		BOOT_CAPT = 2'b01,
		BOOT_RUN = 2'b11
	} fsf_boot_e;

endpackage

// >>> rtl/fsf_flag_cell.sv
// sticky active-low fault flags with write-one restore
`timescale 1ns/1ps
module fsf_flag_cell #(
	parameter int N = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [N-1:0] fault_evt,
	input wire logic [N-1:0] restore,
	output logic [N-1:0] flags_n_ff
);

	logic [N-1:0] nxt_flags_n;

	always_comb begin
		nxt_flags_n = flags_n_ff;
		for (int i = 0; i < N; i++) begin
			if (fault_evt[i]) begin
				// event beats a restore in the same cycle
				nxt_flags_n[i] = 1'b0; // [R4] [R17]
			end else if (restore[i]) begin
				nxt_flags_n[i] = 1'b1; // [R4]
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_n_ff <= '1;
		end else begin
			flags_n_ff <= nxt_flags_n;
		end
	end

endmodule

// >>> rtl/fsf_trip_persist.sv
// counts consecutive conversions past a threshold, pulses on each such conversion once the count is at or past limit
`timescale 1ns/1ps
module fsf_trip_persist #(
	parameter int CW = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic conv_strobe,
	input wire logic past_threshold,
	input wire logic [CW-1:0] limit,
	output logic trip_ff
);

	logic [CW-1:0] run_cnt_ff;
	logic [CW-1:0] nxt_run_cnt;
	logic [CW-1:0] eff_limit;

	// a limit of zero behaves as one conversion
	assign eff_limit = (limit == '0) ? CW'(1) : limit;

	always_comb begin
		nxt_run_cnt = run_cnt_ff;
		if (conv_strobe) begin
			if (!past_threshold) begin
				nxt_run_cnt = '0;
			end else if (run_cnt_ff != '1) begin
				nxt_run_cnt = run_cnt_ff + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_cnt_ff <= '0;
		end else begin
			run_cnt_ff <= nxt_run_cnt;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trip_ff <= 1'b0;
		end else begin
			trip_ff <= conv_strobe && past_threshold && (nxt_run_cnt >= eff_limit);
		end
	end

endmodule

// >>> bench/fsf_bank_props.sv
// port assertions for the fault status bank
`timescale 1ns/1ps
module fsf_bank_props #(
	parameter int PERSIST_W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire fsf_pkg::fsf_reg_req_s reg_req,
	input wire logic [15:0] reg_rdata_ff,
	input wire logic reg_rd_valid_ff,
	input wire logic reg_addr_err_ff,
	input wire fsf_pkg::fsf_crc_evt_s crc_evt,
	input wire logic otp_backup_sel,
	input wire fsf_pkg::fsf_occ_cmp_s occ_cmp,
	input wire logic [fsf_pkg::PIN_RB_W-1:0] pin_readback_in,
	input wire logic summary_digital_fault_n_ff,
	input wire logic summary_occ_fault_n_ff,
	input wire logic boot_done_ff
);
	logic bad_addr;
	logic rd05;
	logic wr05;
	assign bad_addr = !(reg_req.addr inside {8'h05, 8'h06, 8'h07});
	assign rd05 = reg_req.rd && reg_req.addr == 8'h05;
	assign wr05 = reg_req.wr && reg_req.addr == 8'h05;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	read_answer_a: assert property (reg_req.rd |=> reg_rd_valid_ff)
		else $error("read not answered");
	unmapped_err_a: assert property ((reg_req.rd || reg_req.wr) && bad_addr |=> reg_addr_err_ff)
		else $error("unmapped access not flagged");
	unmapped_zero_a: assert property (reg_req.rd && bad_addr |=> reg_rdata_ff == 16'h0000)
		else $error("unmapped read not zero");
	dig_reserved_a: assert property (rd05 |=> !reg_rdata_ff[12] && reg_rdata_ff[9:0] == 10'h000)
		else $error("digital reserved bits set");
	occ_reserved_a: assert property (reg_req.rd && reg_req.addr == 8'h06 |=> reg_rdata_ff[15:4] == 12'h000)
		else $error("overcurrent reserved bits set");
	pin_mirror_a: assert property (reg_req.rd && reg_req.addr == 8'h07 && boot_done_ff && $stable(pin_readback_in)
		|=> reg_rdata_ff == {6'h00, $past(pin_readback_in)})
		else $error("readback wrong");
	boot_capture_a: assert property ($rose(reset_n) |-> !boot_done_ff ##1 !boot_done_ff ##1 boot_done_ff)
		else $error("bank capture late");
	bank_bit_a: assert property (rd05 && boot_done_ff |=> reg_rdata_ff[10] == !$past(otp_backup_sel))
		else $error("bank bit wrong");
	crc_summary_a: assert property (|crc_evt |-> ##2 !summary_digital_fault_n_ff)
		else $error("crc fault not summarised");
	flag_restore_a: assert property (wr05 && reg_req.wdata[15:13] == 3'h7 && reg_req.wdata[11] && !(|crc_evt)
		##1 !(|crc_evt) |=> summary_digital_fault_n_ff)
		else $error("restore failed");
	flag_sticky_a: assert property (!wr05 ##1 !summary_digital_fault_n_ff |=> !summary_digital_fault_n_ff)
		else $error("flag left without restore");
	occ_cause_a: assert property ($fell(summary_occ_fault_n_ff) |-> $past(occ_cmp.conv_a, 3)
		|| $past(occ_cmp.conv_b, 3))
		else $error("trip without conversion");
endmodule
bind fsf_fault_status_bank fsf_bank_props #(.PERSIST_W(PERSIST_W)) u_fsf_bank_props (
	.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
	.reg_rd_valid_ff(reg_rd_valid_ff), .reg_addr_err_ff(reg_addr_err_ff), .crc_evt(crc_evt),
	.otp_backup_sel(otp_backup_sel), .occ_cmp(occ_cmp), .pin_readback_in(pin_readback_in),
	.summary_digital_fault_n_ff(summary_digital_fault_n_ff),
	.summary_occ_fault_n_ff(summary_occ_fault_n_ff), .boot_done_ff(boot_done_ff)
);

// >>> bench/fsf_host_model.sv
// host controller model: register reads and writes
`timescale 1ns/1ps
module fsf_host_model (
	input wire logic clk,
	input wire logic [15:0] reg_rdata_ff,
	input wire logic reg_rd_valid_ff,
	input wire logic reg_addr_err_ff,
	output fsf_pkg::fsf_reg_req_s reg_req,
	output logic reset_wanted
);
	initial begin
		reg_req = '0;
		reset_wanted = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		reg_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [17:0] r);
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge clk);
		reg_req.rd = 1'b0;
		r = {reg_rd_valid_ff, reg_addr_err_ff, reg_rdata_ff};
		// backup bank or memory fault: ask for a device reset
		if (a == 8'h05) reset_wanted = !r[10] || !r[11];
	endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the fault status bank
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	fsf_pkg::fsf_reg_req_s reg_req;
	fsf_pkg::fsf_crc_evt_s crc_evt = '0;
	fsf_pkg::fsf_occ_cmp_s occ_cmp = '0;
	logic otp_sel = 1'b0;
	logic [9:0] pin_rb = 10'h000;
	logic [7:0] occ_limit = 8'h02;
	logic [15:0] rdata;
	logic rd_valid, addr_err, sum_dig_n, sum_occ_n, boot_done, reset_wanted;
	logic [5:0] pat [4] = '{6'b110000, 6'b101000, 6'b000110, 6'b000101};
	int err_total = 0;
	int checks_done = 0;
	always #25 clk = ~clk;
	fsf_fault_status_bank u_fsf_fault_status_bank (
		.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata_ff(rdata),
		.reg_rd_valid_ff(rd_valid), .reg_addr_err_ff(addr_err), .crc_evt(crc_evt),
		.otp_backup_sel(otp_sel), .occ_cmp(occ_cmp), .occ_persist_limit(occ_limit),
		.pin_readback_in(pin_rb), .summary_digital_fault_n_ff(sum_dig_n),
		.summary_occ_fault_n_ff(sum_occ_n), .boot_done_ff(boot_done)
	);
	fsf_host_model u_fsf_host_model (
		.clk(clk), .reg_rdata_ff(rdata), .reg_rd_valid_ff(rd_valid),
		.reg_addr_err_ff(addr_err), .reg_req(reg_req), .reset_wanted(reset_wanted)
	);
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [17:0] exp);
		logic [17:0] r;
		u_fsf_host_model.rd(a, r);
		chk(r, exp);
	endtask
	task automatic do_reset(input logic sel);
		int n;
		reset_n = 1'b0;
		otp_sel = sel;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		for (n = 0; n < 10 && boot_done !== 1'b1; n++) @(negedge clk);
		if (n == 10) begin
			err_total++;
			stop_test();
		end
	endtask
	task automatic t_regs;
		rd_chk(8'h05, {2'b10, 16'hec00});
		rd_chk(8'h06, {2'b10, 16'h000f});
		rd_chk(8'h07, {2'b10, 16'h0000});
		pin_rb = 10'h2a5;
		rd_chk(8'h07, {2'b10, 16'h02a5});
		rd_chk(8'h08, {2'b11, 16'h0000});
		u_fsf_host_model.wr(8'h07, 16'hffff);
		u_fsf_host_model.wr(8'h06, 16'hfff0);
		u_fsf_host_model.wr(8'h05, 16'h17ff);
		rd_chk(8'h05, {2'b10, 16'hec00});
		rd_chk(8'h06, {2'b10, 16'h000f});
	endtask
	task automatic t_crc;
		logic [15:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 16'h0001 << (i == 0 ? 11 : 12 + i);
			@(negedge clk);
			crc_evt = 4'h1 << i;
			@(negedge clk);
			crc_evt = '0;
			repeat (2) @(negedge clk);
			chk({17'h0, sum_dig_n}, 18'h0);
			u_fsf_host_model.wr(8'h05, 16'hffff ^ m);
			rd_chk(8'h05, {2'b10, 16'hec00 ^ m});
			chk({17'h0, reset_wanted}, {17'h0, i == 0});
			u_fsf_host_model.wr(8'h05, m);
			rd_chk(8'h05, {2'b10, 16'hec00});
			chk({17'h0, sum_dig_n}, 18'h1);
		end
		@(negedge clk);
		crc_evt = 4'hf;
		@(negedge clk);
		crc_evt = '0;
		rd_chk(8'h05, {2'b10, 16'h0400});
		u_fsf_host_model.wr(8'h05, 16'hffff);
		rd_chk(8'h05, {2'b10, 16'hec00});
		chk({17'h0, reset_wanted}, 18'h0);
	endtask
	task automatic drv(input logic [5:0] x);
		@(negedge clk);
		occ_cmp = x;
	endtask
	task automatic t_occ;
		logic [15:0] m;
		for (int k = 0; k < 4; k++) begin
			m = 16'h0008 >> k;
			drv(pat[k]);
			drv(6'b100100);
			drv(pat[k] & 6'b011011);
			drv(pat[k]);
			drv(6'h00);
			repeat (2) @(negedge clk);
			rd_chk(8'h06, {2'b10, 16'h000f});
			drv(pat[k]);
			drv(6'h00);
			repeat (2) @(negedge clk);
			rd_chk(8'h06, {2'b10, 16'h000f ^ m});
			chk({17'h0, sum_occ_n}, 18'h0);
			u_fsf_host_model.wr(8'h06, m);
			rd_chk(8'h06, {2'b10, 16'h000f});
		end
		// a limit of zero trips on a single conversion
		occ_limit = 8'h00;
		drv(6'b110000);
		drv(6'h00);
		repeat (2) @(negedge clk);
		rd_chk(8'h06, {2'b10, 16'h0007});
		chk({17'h0, sum_occ_n}, 18'h0);
		u_fsf_host_model.wr(8'h06, 16'h0008);
		rd_chk(8'h06, {2'b10, 16'h000f});
	endtask
	task automatic t_bank;
		@(negedge clk);
		crc_evt = 4'h8;
		@(negedge clk);
		crc_evt = '0;
		do_reset(1'b1);
		rd_chk(8'h05, {2'b10, 16'he800});
		u_fsf_host_model.wr(8'h05, 16'h0400);
		rd_chk(8'h05, {2'b10, 16'he800});
		chk({17'h0, sum_dig_n}, 18'h1);
		chk({17'h0, reset_wanted}, 18'h1);
		do_reset(1'b0);
		rd_chk(8'h05, {2'b10, 16'hec00});
		chk({17'h0, reset_wanted}, 18'h0);
	endtask
	initial begin
		do_reset(1'b0);
		t_regs();
		t_crc();
		t_occ();
		t_bank();
		stop_test();
	end
endmodule
